// >>> verilog/nosb_top.v
// NAND-over-static-bank sequencer: boot strap decode, boot-time NAND
// control generation on address pins, and normal address passthrough.
// Assumes strap pins and reset-out are asynchronous pins; bus side is
// on clk_i.
// Operation
// - Capture four strap pins when reset-out rises; pick boot source.
// - Strap bit two high means NAND, I2C or UART boot.
// - Codes 0/1 16-bit, 2/3 8-bit, 8/9 32-bit; odd holds lanes high.
// - First revision: NAND codes 4-7, C, D; A, B, E, F reserved.
// - Second revision: 6 and D take 4/5 bytes; E I2C, F UART.
// - During NAND boot drive ALE, CLE, write and read strobes.
// - Boot shifts controls so pins match for 8- and 16-bit widths.
// - Width 01 means 16-bit, address bit 1 on pin 0.
`timescale 1ns/1ps
`include "nosb_regs.vh"
module nosb_top (
  input wire clk_i,
  input wire arst_n_i,
  input wire reset_out_n_i,
  input wire [3:0] boot_strap_pins_i,
  input wire silicon_rev_b_i,
  input wire boot_done_i,
  input wire [1:0] memory_width_field_i,
  input wire bus_valid_i,
  input wire bus_write_i,
  input wire [24:0] bus_addr_i,
  input wire [7:0] boot_cmd_i,
  input wire boot_cmd_is_addr_i,
  input wire boot_cmd_valid_i,
  input wire boot_rd_valid_i,
  output wire boot_busy_o,
  output reg [23:0] addr_o,
  output reg chip_select_zero_n_o,
  output reg [1:0] boot_source_o,
  output reg [1:0] boot_width_o,
  output reg boot_lanes_high_o,
  output reg [2:0] boot_addr_bytes_o,
  output reg boot_large_block_o,
  output reg boot_reserved_o,
  output reg in_nand_boot_o
);
  localparam S_IDLE = 5'h01;
  localparam S_SETUP = 5'h02;
  localparam S_STRB = 5'h04;
  localparam S_HOLD = 5'h08;
  localparam S_CLEAR = 5'h10;

  reg [1:0] rst_sync_ff;
  reg [3:0] strap_s1_ff;
  reg [3:0] strap_s2_ff;
  reg rst_prev_ff;
  reg [3:0] code_ff;
  reg [4:0] state_ff;
  reg [4:0] nxt_state;
  reg [3:0] cnt_ff;
  reg [3:0] nxt_cnt;
  reg op_addr_ff;
  reg op_rd_ff;
  reg [24:0] ctl_addr;
  wire [23:0] shifted;
  wire rise;

  // Two-flop synchronisers for pins
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_ff <= 2'h0;
      strap_s1_ff <= 4'h0;
      strap_s2_ff <= 4'h0;
      rst_prev_ff <= 1'b0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], reset_out_n_i};
      strap_s1_ff <= boot_strap_pins_i;
      strap_s2_ff <= strap_s1_ff;
      rst_prev_ff <= rst_sync_ff[1];
    end
  end

  assign rise = rst_sync_ff[1] & ~rst_prev_ff;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      code_ff <= 4'h0;
    end else if (rise) begin
      code_ff <= strap_s2_ff;
    end
  end

  // Decode of captured code; latched so outputs come from flops
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      boot_source_o <= `NOSB_SRC_NOR;
      boot_width_o <= `NOSB_MW_16;
      boot_lanes_high_o <= 1'b0;
      boot_addr_bytes_o <= 3'h0;
      boot_large_block_o <= 1'b0;
      boot_reserved_o <= 1'b0;
    end else begin
      boot_lanes_high_o <= code_ff[0] & ~code_ff[`NOSB_STRAP_NAND_BIT];
      boot_large_block_o <= 1'b0;
      boot_reserved_o <= 1'b0;
      boot_addr_bytes_o <= 3'h0;
      boot_source_o <= code_ff[`NOSB_STRAP_NAND_BIT] ?
                       `NOSB_SRC_NAND : `NOSB_SRC_NOR;
      case (code_ff)
        `NOSB_SC_NOR16_LO, `NOSB_SC_NOR16_HI: boot_width_o <= `NOSB_MW_16;
        `NOSB_SC_NOR8_LO, `NOSB_SC_NOR8_HI: boot_width_o <= `NOSB_MW_8;
        `NOSB_SC_NOR32_LO, `NOSB_SC_NOR32_HI: boot_width_o <= `NOSB_MW_32;
        `NOSB_SC_NAND8_3: begin
          boot_width_o <= `NOSB_MW_8;
          boot_addr_bytes_o <= 3'h3;
        end
        `NOSB_SC_NAND8_4: begin
          boot_width_o <= `NOSB_MW_8;
          boot_addr_bytes_o <= 3'h4;
        end
        // Later revision takes 4 or 5 bytes, reports 5
        `NOSB_SC_NAND8_5: begin
          boot_width_o <= `NOSB_MW_8;
          boot_addr_bytes_o <= 3'h5;
        end
        `NOSB_SC_NAND16_3: begin
          boot_width_o <= `NOSB_MW_16;
          boot_addr_bytes_o <= 3'h3;
          boot_large_block_o <= silicon_rev_b_i;
        end
        `NOSB_SC_NAND16_4: begin
          boot_width_o <= `NOSB_MW_16;
          boot_addr_bytes_o <= 3'h4;
        end
        `NOSB_SC_NAND16_5: begin
          boot_width_o <= `NOSB_MW_16;
          boot_addr_bytes_o <= 3'h5;
          boot_large_block_o <= silicon_rev_b_i;
        end
        // Serial boots on second revision only
        `NOSB_SC_I2C: begin
          boot_width_o <= `NOSB_MW_8;
          boot_source_o <= silicon_rev_b_i ? `NOSB_SRC_I2C : `NOSB_SRC_NOR;
          boot_reserved_o <= ~silicon_rev_b_i;
        end
        `NOSB_SC_UART: begin
          boot_width_o <= `NOSB_MW_8;
          boot_source_o <= silicon_rev_b_i ? `NOSB_SRC_UART : `NOSB_SRC_NOR;
          boot_reserved_o <= ~silicon_rev_b_i;
        end
        default: begin
          boot_width_o <= `NOSB_MW_8;
          boot_reserved_o <= 1'b1;
        end
      endcase
    end
  end

  // NAND boot window lasts from reset-out release until boot code ends.
  // Opened from the raw strap code: the decoded source lags one cycle
  // and would otherwise shut a fresh window on the previous code.
  // Window on NAND codes
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      in_nand_boot_o <= 1'b0;
    end else if (!rst_sync_ff[1]) begin
      in_nand_boot_o <= 1'b0;
    end else if (rise) begin
      in_nand_boot_o <= strap_s2_ff[`NOSB_STRAP_NAND_BIT] &&
                        (strap_s2_ff != `NOSB_SC_I2C) &&
                        (strap_s2_ff != `NOSB_SC_UART);
    end else if (boot_done_i) begin
      in_nand_boot_o <= 1'b0;
    end
  end

  // Boot control sequencer: setup, strobe low, strobe high, clear
  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      S_IDLE: begin
        if (in_nand_boot_o && (boot_cmd_valid_i || boot_rd_valid_i)) begin
          nxt_state = S_SETUP;
          nxt_cnt = `NOSB_STEP_CYC;
        end
      end
      S_SETUP, S_STRB, S_HOLD: begin
        if (cnt_ff == 4'h0) begin
          nxt_state = (state_ff == S_SETUP) ? S_STRB :
                      (state_ff == S_STRB) ? S_HOLD : S_CLEAR;
          nxt_cnt = `NOSB_STEP_CYC;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      S_CLEAR: begin
        nxt_state = S_IDLE;
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= S_IDLE;
      cnt_ff <= 4'h0;
      op_addr_ff <= 1'b0;
      op_rd_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      if (state_ff == S_IDLE) begin
        op_addr_ff <= boot_cmd_is_addr_i;
        op_rd_ff <= boot_rd_valid_i & ~boot_cmd_valid_i;
      end
    end
  end

  assign boot_busy_o = (state_ff != S_IDLE);

  // Control levels on the address lines, in the 8-bit view
  // the width shift below is then undone by shifting up first.
  always @* begin
    ctl_addr = 25'h0;
    if (state_ff != S_IDLE) begin
      ctl_addr[`NOSB_ALE_BIT] = op_addr_ff & ~op_rd_ff &
                                (state_ff != S_CLEAR);
      ctl_addr[`NOSB_CLE_BIT] = ~op_addr_ff & ~op_rd_ff &
                                (state_ff != S_CLEAR);
      ctl_addr[`NOSB_WE_BIT] = op_rd_ff | (state_ff != S_STRB);
      ctl_addr[`NOSB_RE_BIT] = ~op_rd_ff | (state_ff != S_STRB);
    end else begin
      ctl_addr[`NOSB_WE_BIT] = 1'b1;
      ctl_addr[`NOSB_RE_BIT] = 1'b1;
    end
    // Pre-shift so pins land alike at 8 and 16-bit widths; 32-bit drops the read strobe
    case (boot_width_o)
      `NOSB_MW_16: ctl_addr = {ctl_addr[23:0], 1'b0};
      `NOSB_MW_32: ctl_addr = {ctl_addr[22:0], 2'h0};
      default: ctl_addr = ctl_addr;
    endcase
  end

  // Right-justify bus addresses by bank width
  nosb_addr_shift u_shift (
    .addr_i(in_nand_boot_o ? ctl_addr : bus_addr_i),
    .width_i(in_nand_boot_o ? boot_width_o : memory_width_field_i),
    .pin_o(shifted)
  );

  // Pins registered; plain addresses outside boot
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_o <= 24'h0;
      chip_select_zero_n_o <= 1'b1;
    end else begin
      addr_o <= shifted;
      // Boot NAND sits on chip select zero only
      chip_select_zero_n_o <= in_nand_boot_o ? ~boot_busy_o : ~bus_valid_i;
    end
  end
endmodule

// >>> verilog/nosb_regs.vh
// Constants for the NAND-over-static-bank sequencer.
// Included by the design files; definitions only.
`ifndef NOSB_REGS_VH
`define NOSB_REGS_VH
// Boot strap codes
`define NOSB_SC_NOR16_LO 4'h0
`define NOSB_SC_NOR16_HI 4'h1
`define NOSB_SC_NOR8_LO 4'h2
`define NOSB_SC_NOR8_HI 4'h3
`define NOSB_SC_NAND8_3 4'h4
`define NOSB_SC_NAND8_4 4'h5
`define NOSB_SC_NAND8_5 4'h6
`define NOSB_SC_NAND16_3 4'h7
`define NOSB_SC_NOR32_LO 4'h8
`define NOSB_SC_NOR32_HI 4'h9
`define NOSB_SC_NAND16_4 4'hC
`define NOSB_SC_NAND16_5 4'hD
`define NOSB_SC_I2C 4'hE
`define NOSB_SC_UART 4'hF
`define NOSB_STRAP_NAND_BIT 2
// Boot source encodings
`define NOSB_SRC_NOR 2'h0
`define NOSB_SRC_NAND 2'h1
`define NOSB_SRC_I2C 2'h2
`define NOSB_SRC_UART 2'h3
// Width encodings (memory width field)
`define NOSB_MW_8 2'h0
`define NOSB_MW_16 2'h1
`define NOSB_MW_32 2'h2
// Internal address bits of the NAND controls, 8-bit view
`define NOSB_ALE_BIT 2
`define NOSB_CLE_BIT 3
`define NOSB_WE_BIT 22
`define NOSB_RE_BIT 23
// Boot sequencer step counter reload; setup, strobe and hold steps each last one clock more
`define NOSB_STEP_CYC 4'h3
`endif

// >>> verilog/nosb_addr_shift.v
// Address justifier for the static bank.
// Pure combinational; fed from the parent's boot controls or raw bus inputs.
`timescale 1ns/1ps
`include "nosb_regs.vh"
module nosb_addr_shift (
  input wire [24:0] addr_i,
  input wire [1:0] width_i,
  output reg [23:0] pin_o
);
  // Right-justify by the bank width
  always @* begin
    case (width_i)
      `NOSB_MW_16: pin_o = addr_i[24:1];
      `NOSB_MW_32: pin_o = {1'b0, addr_i[24:2]};
      default: pin_o = addr_i[23:0];
    endcase
  end
endmodule

// >>> testbench/nosb_nand_model.sv
// Behavioural NAND flash on the boot chip select; counts units.
// Assumes ALE pin 2, CLE pin 3, write strobe 22, read strobe 23.
`timescale 1ns/1ps
module nosb_nand_model (
  input wire sel_i,
  input wire [23:0] pins_i,
  output integer n_addr_o,
  output integer n_cmd_o,
  output integer n_rd_o
);
  initial begin
    n_addr_o = 0;
    n_cmd_o = 0;
    n_rd_o = 0;
  end
  // strobe low with a latch line up
  always @(negedge pins_i[22]) begin
    if (sel_i && pins_i[2]) n_addr_o = n_addr_o + 1;
    if (sel_i && pins_i[3]) n_cmd_o = n_cmd_o + 1;
  end
  // Read only with write strobe parked high, so idle entry is ignored
  always @(negedge pins_i[23]) begin
    if (sel_i && pins_i[22]) n_rd_o = n_rd_o + 1;
  end
endmodule

// >>> testbench/nosb_top_assertions.sv
// Port checker for the NAND-over-static-bank sequencer.
// Assumes one clock domain; bound to nosb_top below.
`timescale 1ns/1ps
module nosb_top_assertions (
  input wire clk_i,
  input wire arst_n_i,
  input wire reset_out_n_i,
  input wire [3:0] boot_strap_pins_i,
  input wire [1:0] memory_width_field_i,
  input wire bus_valid_i,
  input wire [24:0] bus_addr_i,
  input wire boot_cmd_is_addr_i,
  input wire boot_cmd_valid_i,
  input wire boot_rd_valid_i,
  input wire boot_done_i,
  input wire boot_busy_o,
  input wire [23:0] addr_o,
  input wire chip_select_zero_n_o,
  input wire in_nand_boot_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Sequencer idle and outside the boot window
  wire norm = !in_nand_boot_o && !boot_busy_o;
  req_take_a: assert property (
    !boot_busy_o && in_nand_boot_o && boot_cmd_valid_i |=> boot_busy_o)
    else $error("boot request not taken");
  busy_len_a: assert property (
    $rose(boot_busy_o) |-> boot_busy_o[*8] ##5 boot_busy_o ##1 !boot_busy_o)
    else $error("boot cycle length wrong");
  addr_seq_a: assert property (
    $rose(boot_busy_o) && $past(boot_cmd_valid_i && boot_cmd_is_addr_i)
    |-> ##1 addr_o[2] && addr_o[22] ##4 !addr_o[22] && addr_o[2]
    ##4 addr_o[22] && addr_o[23] ##4 !addr_o[2])
    else $error("address byte cycle wrong");
  cmd_seq_a: assert property (
    $rose(boot_busy_o) && $past(boot_cmd_valid_i && !boot_cmd_is_addr_i)
    |-> ##1 addr_o[3] && addr_o[22] ##4 !addr_o[22] && addr_o[3]
    ##4 addr_o[22] ##4 !addr_o[3])
    else $error("command cycle wrong");
  rd_seq_a: assert property (
    $rose(boot_busy_o) && $past(boot_rd_valid_i && !boot_cmd_valid_i)
    |-> ##1 addr_o[23] ##4 !addr_o[23] && addr_o[22] ##4 addr_o[23])
    else $error("read cycle wrong");
  norm_shift_a: assert property (
    norm && !memory_width_field_i[1] ##1 !in_nand_boot_o |-> addr_o ==
    ($past(memory_width_field_i[0]) ? $past(bus_addr_i[24:1])
    : $past(bus_addr_i[23:0])))
    else $error("normal address pins wrong");
  cs_follow_a: assert property (
    norm ##1 !in_nand_boot_o |-> chip_select_zero_n_o == !$past(bus_valid_i))
    else $error("chip select wrong");
  // Reset-out rise reaches the window three edges after the pin moves
  boot_exit_a: assert property (
    (norm || boot_done_i && !boot_busy_o) &&
    !($past(reset_out_n_i, 2) && !$past(reset_out_n_i, 3))
    |=> !in_nand_boot_o)
    else $error("boot window not closed");
  boot_enter_a: assert property (
    $past(reset_out_n_i, 2) && !$past(reset_out_n_i, 3) |=>
    in_nand_boot_o == ($past(boot_strap_pins_i[2], 3) &&
    $past(boot_strap_pins_i[3:1], 3) != 3'h7))
    else $error("boot window entry wrong");
endmodule
bind nosb_top nosb_top_assertions chk (
  .clk_i(clk_i),
  .arst_n_i(arst_n_i),
  .reset_out_n_i(reset_out_n_i),
  .boot_strap_pins_i(boot_strap_pins_i),
  .memory_width_field_i(memory_width_field_i),
  .bus_valid_i(bus_valid_i),
  .bus_addr_i(bus_addr_i),
  .boot_cmd_is_addr_i(boot_cmd_is_addr_i),
  .boot_cmd_valid_i(boot_cmd_valid_i),
  .boot_rd_valid_i(boot_rd_valid_i),
  .boot_done_i(boot_done_i),
  .boot_busy_o(boot_busy_o),
  .addr_o(addr_o),
  .chip_select_zero_n_o(chip_select_zero_n_o),
  .in_nand_boot_o(in_nand_boot_o)
);

// >>> testbench/nosb_top_tb.sv
// Self-checking bench: strap decode, boot cycles, normal pins.
// Assumes nosb_top, the NAND model and the checker are compiled.
`timescale 1ns/1ps
module nosb_top_tb;
  reg clk_i = 1'b0;
  reg arst_n_i = 1'b0;
  reg reset_out_n_i = 1'b0;
  reg [3:0] boot_strap_pins_i = 4'h0;
  reg silicon_rev_b_i = 1'b0;
  reg boot_done_i = 1'b0;
  reg [1:0] memory_width_field_i = 2'h0;
  reg bus_valid_i = 1'b0;
  reg bus_write_i = 1'b0;
  reg [24:0] bus_addr_i = 25'h0000000;
  reg [7:0] boot_cmd_i = 8'h00;
  reg boot_cmd_is_addr_i = 1'b0;
  reg boot_cmd_valid_i = 1'b0;
  reg boot_rd_valid_i = 1'b0;
  wire boot_busy_o, chip_select_zero_n_o, boot_lanes_high_o;
  wire boot_large_block_o, boot_reserved_o, in_nand_boot_o;
  wire [23:0] addr_o;
  wire [1:0] boot_source_o, boot_width_o;
  wire [2:0] boot_addr_bytes_o;
  reg [7:0] e;
  reg [23:0] p;
  integer failures = 0, n_tests = 0, na, nc, nr, i, j, k, c, r;
  nosb_top dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .reset_out_n_i(reset_out_n_i), .boot_strap_pins_i(boot_strap_pins_i),
    .silicon_rev_b_i(silicon_rev_b_i), .boot_done_i(boot_done_i),
    .memory_width_field_i(memory_width_field_i),
    .bus_valid_i(bus_valid_i), .bus_write_i(bus_write_i),
    .bus_addr_i(bus_addr_i), .boot_cmd_i(boot_cmd_i),
    .boot_cmd_is_addr_i(boot_cmd_is_addr_i),
    .boot_cmd_valid_i(boot_cmd_valid_i), .boot_rd_valid_i(boot_rd_valid_i),
    .boot_busy_o(boot_busy_o), .addr_o(addr_o),
    .chip_select_zero_n_o(chip_select_zero_n_o),
    .boot_source_o(boot_source_o), .boot_width_o(boot_width_o),
    .boot_lanes_high_o(boot_lanes_high_o),
    .boot_addr_bytes_o(boot_addr_bytes_o),
    .boot_large_block_o(boot_large_block_o),
    .boot_reserved_o(boot_reserved_o), .in_nand_boot_o(in_nand_boot_o));
  nosb_nand_model m (.sel_i(in_nand_boot_o), .pins_i(addr_o),
    .n_addr_o(), .n_cmd_o(), .n_rd_o());
  always #50 clk_i = ~clk_i;
  task check(input [63:0] seen, input [63:0] exp, input [95:0] what);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("mismatch %0s exp %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task stop_test;
    begin
      if (failures == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // Bounded wait on the busy flag; a hang ends the run
  task wait_busy(input lvl);
    begin
      k = 0;
      while (boot_busy_o !== lvl && k < 40) begin
        @(posedge clk_i);
        #1 k = k + 1;
      end
      if (boot_busy_o !== lvl) begin
        failures = failures + 1;
        stop_test;
      end
    end
  endtask
  // Kind 0 address byte, 1 command, 2 read; valid held one busy edge
  task boot_req(input integer kind);
    begin
      @(posedge clk_i);
      r = $urandom;
      boot_cmd_i <= r[7:0];
      boot_cmd_is_addr_i <= (kind == 0);
      boot_cmd_valid_i <= (kind < 2);
      boot_rd_valid_i <= (kind == 2);
      #1 wait_busy(1'b1);
      @(posedge clk_i);
      boot_cmd_valid_i <= 1'b0;
      boot_rd_valid_i <= 1'b0;
      #1 wait_busy(1'b0);
    end
  endtask
  // Expected {source, reserved, lanes, bytes, large}
  function [7:0] dec(input [3:0] s, input b);
    reg n;
    begin
      n = (s[3:2] == 2'h1) || (s[3:1] == 3'h6);
      dec[7:6] = n ? 2'h1 : (b && s[3:1] == 3'h7) ? {1'b1, s[0]} : 2'h0;
      dec[5] = (s[3:1] == 3'h5) || (!b && s[3:1] == 3'h7);
      dec[4] = s[0] && !s[2];
      dec[3:1] = !n ? 3'h0 : (s == 4'h4 || s == 4'h7) ? 3'h3
        : (s == 4'h5 || s == 4'hC) ? 3'h4 : 3'h5;
      dec[0] = b && (s == 4'h7 || s == 4'hD);
    end
  endfunction
  function [1:0] wid(input [3:0] s);
    wid = (s[3:1] == 3'h1 || s[3:2] == 2'h1 && s != 4'h7) ? 2'h0
      : (s[3:1] == 3'h4) ? 2'h2 : 2'h1;
  endfunction
  // Expected pins: address right-justified by the bank width
  function [23:0] pin_exp(input [24:0] a, input [1:0] w);
    pin_exp = (w == 2'h1) ? a[24:1] : (w == 2'h2) ? {1'b0, a[24:2]}
      : a[23:0];
  endfunction
  initial begin
    c = $urandom(5127);
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (i = 0; i < 32; i = i + 1) begin
      @(posedge clk_i);
      reset_out_n_i <= 1'b0;
      boot_strap_pins_i <= i[3:0];
      silicon_rev_b_i <= i[4];
      repeat (3) @(posedge clk_i);
      reset_out_n_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      #1 e = dec(i[3:0], i[4]);
      check({boot_source_o, boot_reserved_o, boot_lanes_high_o,
        boot_addr_bytes_o, boot_large_block_o}, e, "decode");
      check(in_nand_boot_o, e[7:6] == 2'h1, "window");
      if (!e[5] && !e[7]) check(boot_width_o, wid(i[3:0]), "width");
      // bus kept quiet while the boot device is driven
      if (in_nand_boot_o === 1'b1) begin
        na = m.n_addr_o;
        nc = m.n_cmd_o;
        nr = m.n_rd_o;
        c = $urandom % 3;
        for (j = 0; j < 3; j = j + 1) boot_req((c + j) % 3);
        check(m.n_addr_o - na, 1, "addr bytes");
        check(m.n_cmd_o - nc, 1, "commands");
        check(m.n_rd_o - nr, 1, "reads");
        @(posedge clk_i);
        boot_done_i <= 1'b1;
        @(posedge clk_i);
        boot_done_i <= 1'b0;
      end
      for (j = 0; j < 4; j = j + 1) begin
        @(posedge clk_i);
        r = $urandom;
        bus_addr_i <= (j == 0) ? (i[0] ? 25'h1000020 : 25'h0800010)
          : (j == 1) ? 25'h1800018 : r[24:0];
        memory_width_field_i <= (j == 0) ? {1'b0, i[0]}
          : (j == 1) ? 2'h1 : r[26:25] % 2'h3;
        bus_valid_i <= r[27];
        bus_write_i <= r[28];
        @(posedge clk_i);
        #1 p = pin_exp(bus_addr_i, memory_width_field_i);
        check(addr_o, p, "pins");
        if (j == 1) check(addr_o, 24'hC0000C, "ctl pins");
        check(chip_select_zero_n_o, !bus_valid_i, "cs");
      end
      bus_valid_i <= 1'b0;
    end
    stop_test;
  end
endmodule
